/* File: rtl/cig_channel_front.sv */
// one receiver channel front end: port and sync select, qualifier gating,
// exponent-aware scaling and the resampling comb, with an AHB-Lite slave
// assumes one master clock; port pins arrive from outside its domain
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cig_defs.svh"
module cig_channel_front
  import cig_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // wideband input ports
  input  wire logic [15:0] port_a_samples,
  input  wire logic [2:0]  port_a_gain_exponent,
  input  wire logic        port_a_qualifier,
  input  wire logic [15:0] port_b_samples,
  input  wire logic [2:0]  port_b_gain_exponent,
  input  wire logic        port_b_qualifier,
  input  wire logic        sync_pin_a,
  input  wire logic        sync_pin_b,
  input  wire logic        sync_pin_c,
  input  wire logic        sync_pin_d,
  // channel outputs
  output logic             chan_sync,
  output logic             nco_advance,
  output logic             backend_run,
  output cig_sample_t      chan_sample,
  output logic             chan_valid,
  output cig_rs_out_t      rs_data,
  output logic             rs_valid
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int PW = 2 * (16 + 3 + 1) + 4;

  logic [PW-1:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;

  assign pin_raw = {port_a_samples, port_a_gain_exponent, port_a_qualifier,
                    port_b_samples, port_b_gain_exponent, port_b_qualifier,
                    sync_pin_d, sync_pin_c, sync_pin_b, sync_pin_a};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // a bit moves only once the second and third stages agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_f_reg <= '0;
    end else begin
      for (int i = 0; i < PW; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_f_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  logic [15:0] a_smp, b_smp;
  logic [2:0]  a_exp, b_exp;
  logic        a_q, b_q;
  logic [3:0]  sync_f;

  assign {a_smp, a_exp, a_q, b_smp, b_exp, b_q, sync_f} = pin_f_reg;

  // ************************************************************
  // registers and AHB-Lite slave
  // ************************************************************
  logic [`CIG_CFG_WIDTH-1:0] config_reg, config_next;
  logic [11:0]               decim_reg, decim_next;
  logic [8:0]                interp_reg, interp_next;
  logic [`CIG_SCL_WIDTH-1:0] scale_reg, scale_next;
  logic [15:0]               nco_count_reg;
  logic                      wr_pend_reg;
  logic [7:0]                wr_idx_reg;
  logic                      addr_ok, rd_take, wr_take;
  logic [7:0]                a_idx;
  logic [31:0]               rd_value;

  assign a_idx   = haddr[9:2];
  // words only: any other size or a misaligned address is left unmapped
  assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'b010)
                   && (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= wr_take;
      wr_idx_reg  <= a_idx;
    end
  end

  // next values carry a data-phase write so a read right behind it sees it
  always_comb begin
    config_next = config_reg;
    decim_next  = decim_reg;
    interp_next = interp_reg;
    scale_next  = scale_reg;
    if (wr_pend_reg) begin
      if (wr_idx_reg == `CIG_IDX_CONFIG) begin
        config_next = hwdata[`CIG_CFG_WIDTH-1:0];
      end else if (wr_idx_reg == `CIG_IDX_DECIM) begin
        decim_next = hwdata[11:0];
      end else if (wr_idx_reg == `CIG_IDX_INTERP) begin
        interp_next = hwdata[8:0];
      end else if (wr_idx_reg == `CIG_IDX_SCALE) begin
        scale_next = hwdata[`CIG_SCL_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      config_reg <= `CIG_RST_CONFIG;
      decim_reg  <= `CIG_RST_DECIM;
      interp_reg <= `CIG_RST_INTERP;
      scale_reg  <= `CIG_RST_SCALE;
    end else begin
      config_reg <= config_next;
      decim_reg  <= decim_next;
      interp_reg <= interp_next;
      scale_reg  <= scale_next;
    end
  end

  always_comb begin
    rd_value = 32'h00000000;
    if (a_idx == `CIG_IDX_CONFIG) begin
      rd_value = 32'(config_next);
    end else if (a_idx == `CIG_IDX_DECIM) begin
      rd_value = 32'(decim_next);
    end else if (a_idx == `CIG_IDX_INTERP) begin
      rd_value = 32'(interp_next);
    end else if (a_idx == `CIG_IDX_SCALE) begin
      rd_value = 32'(scale_next);
    end else if (a_idx == `CIG_IDX_STATUS) begin
      rd_value = {nco_count_reg, 14'h0000, chan_sync, backend_run};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_take) begin
        hrdata <= rd_value;
      end
    end
  end

  // ************************************************************
  // port, sync and mode selection
  // ************************************************************
  logic        port_b;
  logic [1:0]  sync_sel;
  logic        sel_q;
  logic [15:0] sel_smp;
  logic [2:0]  sel_exp;

  assign port_b   = config_reg[`CIG_CFG_PORTB_BIT];
  assign sync_sel = config_reg[`CIG_CFG_SYNC_LSB +: 2];
  assign sel_q    = port_b ? b_q   : a_q;
  assign sel_smp  = port_b ? b_smp : a_smp;
  assign sel_exp  = port_b ? b_exp : a_exp;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_sync <= 1'b0;
    end else begin
      chan_sync <= sync_f[sync_sel];
    end
  end

  cig_gate_if gate ();

  assign gate.mode = cig_qmode_t'(config_reg[`CIG_CFG_QMODE_LSB +: 2]);
  assign gate.qual = sel_q;

  cig_qual_decode u_qual (
    .clk  (clk),
    .rstn (rstn),
    .gate (gate.decoder)
  );

  // ************************************************************
  // exponent-aware input scaling
  // ************************************************************
  logic [4:0] scale_val;
  logic [2:0] exp_eff;
  logic [3:0] exp_term;
  logic [2:0] shift;

  // the weak-signal field is taken while the channel is flagged weak
  assign scale_val = config_reg[`CIG_CFG_WEAK_BIT]
                   ? scale_reg[`CIG_SCL_WEAK_LSB +: 5]
                   : scale_reg[`CIG_SCL_STRONG_LSB +: 5];
  assign exp_eff   = scale_reg[`CIG_SCL_INV_BIT]
                   ? (`CIG_EXP_MAX - sel_exp) : sel_exp;
  assign exp_term  = scale_reg[`CIG_SCL_STEP12_BIT]
                   ? {exp_eff, 1'b0} : {1'b0, exp_eff};
  // only the low three bits survive the modulo-8 shift
  assign shift     = 3'(exp_term) + scale_val[2:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_sample <= '0;
      chan_valid  <= 1'b0;
    end else begin
      chan_valid <= gate.capture;
      if (gate.capture && gate.zero_fill) begin
        chan_sample <= '0;
      end else if (gate.capture) begin
        chan_sample <= $signed(sel_smp) >>> shift;
      end
    end
  end

  // ************************************************************
  // NCO advance and back-end run strobes
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nco_advance   <= 1'b0;
      backend_run   <= 1'b0;
      nco_count_reg <= 16'h0000;
    end else begin
      nco_advance <= gate.nco_adv;
      backend_run <= gate.backend;
      if (gate.nco_adv) begin
        nco_count_reg <= nco_count_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // resampling comb
  // ************************************************************
  cig_resampler u_rs (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (chan_valid),
    .in_data   (chan_sample),
    .l_m1      (interp_reg),
    .m_m1      (decim_reg),
    .out_data  (rs_data),
    .out_valid (rs_valid)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  // an attempt started on the release edge would see reset-time outputs
  logic chk_live_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_live_reg <= 1'b0;
    end else begin
      chk_live_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!chk_live_reg);

  logic bypass_now;
  assign bypass_now = (interp_reg == 9'h000) && (decim_reg == 12'h000);

  a_blank_zero: assert property (
    (gate.mode == CIG_QM_BLANK) && !sel_q |=> chan_valid && chan_sample == 0)
    else $error("blanked sample not zero");
  a_blank_nco: assert property (
    (gate.mode == CIG_QM_BLANK) |=> nco_advance)
    else $error("nco stopped in blank mode");
  a_blank_backend: assert property (
    (gate.mode == CIG_QM_BLANK) && sel_q |=> backend_run)
    else $error("back end idle while qualified");
  a_level_hold: assert property (
    (gate.mode == CIG_QM_LEVEL) && !sel_q |=> !chan_valid && !nco_advance)
    else $error("level mode latched while low");
  a_level_run: assert property (
    (gate.mode == CIG_QM_LEVEL) && sel_q |=> chan_valid && backend_run)
    else $error("level mode missed a sample");
  a_rise_once: assert property (
    (gate.mode == CIG_QM_RISE) ##1 (gate.mode == CIG_QM_RISE) && sel_q
    |=> chan_valid == !$past(sel_q, 2))
    else $error("rise mode capture wrong");
  a_fall_once: assert property (
    (gate.mode == CIG_QM_FALL) ##1 (gate.mode == CIG_QM_FALL) && !sel_q
    |=> chan_valid == $past(sel_q, 2))
    else $error("fall mode capture wrong");
  a_edge_nco: assert property (
    gate.mode[1] |=> nco_advance == chan_valid && backend_run)
    else $error("edge mode nco not tied to capture");
  a_sync_route: assert property (
    $stable(sync_sel) |=> chan_sync == $past(sync_f[sync_sel]))
    else $error("sync pin routing wrong");
  a_bypass_pass: assert property (
    bypass_now && chan_valid |=> rs_valid && rs_data == 24'($past(chan_sample)))
    else $error("bypass did not pass sample");

  c_blank_gap: cover property (
    (gate.mode == CIG_QM_BLANK) && sel_q ##1 !sel_q [*3] ##1 sel_q);
  c_rise_cap: cover property ((gate.mode == CIG_QM_RISE) && gate.capture);
  c_fall_cap: cover property ((gate.mode == CIG_QM_FALL) && gate.capture);
  c_resample: cover property (!bypass_now && rs_valid);

endmodule // cig_channel_front

/* File: rtl/cig_defs.svh */
// constants of the channel input gate: register indices, fields, resets
// assumes byte address = register index times four on a 32-bit bus
`ifndef CIG_DEFS_SVH
`define CIG_DEFS_SVH

// register indices
`define CIG_IDX_CONFIG     8'h8A
`define CIG_IDX_DECIM      8'h90
`define CIG_IDX_INTERP     8'h91
`define CIG_IDX_SCALE      8'h92
`define CIG_IDX_STATUS     8'h93

// channel_config fields
`define CIG_CFG_QMODE_LSB  0
`define CIG_CFG_PORTB_BIT  6
`define CIG_CFG_SYNC_LSB   7
`define CIG_CFG_WEAK_BIT   9
`define CIG_CFG_WIDTH      10

// resampler_scale_control fields
`define CIG_SCL_STRONG_LSB 0
`define CIG_SCL_WEAK_LSB   5
`define CIG_SCL_STEP12_BIT 10
`define CIG_SCL_INV_BIT    11
`define CIG_SCL_WIDTH      12

// reset values and the largest exponent
`define CIG_RST_CONFIG     10'h000
`define CIG_RST_DECIM      12'h000
`define CIG_RST_INTERP     9'h000
`define CIG_RST_SCALE      12'h000
`define CIG_EXP_MAX        3'h7

`endif

/* File: rtl/cig_pkg.sv */
// types shared by the channel input gate modules
// assumes cig_defs.svh holds the numeric constants
package cig_pkg;

  // qualifier modes in register order: 00, 01, 10, 11
  typedef enum logic [1:0] {
    CIG_QM_BLANK,
    CIG_QM_LEVEL,
    CIG_QM_RISE,
    CIG_QM_FALL
  } cig_qmode_t;

  typedef logic signed [15:0] cig_sample_t;
  typedef logic signed [23:0] cig_rs_out_t;

endpackage

/* File: rtl/cig_gate_if.sv */
// gate signals between the channel top and the qualifier decoder
// assumes both ends run on the one master clock
`timescale 1ns/1ps
interface cig_gate_if;
  import cig_pkg::*;
  cig_qmode_t mode;
  logic       qual;
  logic       capture;
  logic       zero_fill;
  logic       nco_adv;
  logic       backend;

  modport decoder (input mode, input qual,
                   output capture, output zero_fill,
                   output nco_adv, output backend);
  modport channel (output mode, output qual,
                   input capture, input zero_fill,
                   input nco_adv, input backend);
endinterface

/* File: rtl/cig_qual_decode.sv */
// qualifier decoder: turns mode and qualifier level into gate strobes
// assumes qual is already synchronised to clk
`timescale 1ns/1ps
module cig_qual_decode
  import cig_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rstn,
  cig_gate_if.decoder gate
);

  logic qual_prev_reg;

  // edges are found against the previous registered level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qual_prev_reg <= 1'b0;
    end else begin
      qual_prev_reg <= gate.qual;
    end
  end

  always_comb begin
    gate.capture   = 1'b0;
    gate.zero_fill = 1'b0;
    gate.nco_adv   = 1'b0;
    gate.backend   = 1'b1;
    case (gate.mode)
      CIG_QM_BLANK: begin
        gate.capture   = 1'b1;
        gate.zero_fill = !gate.qual;
        gate.nco_adv   = 1'b1;
        gate.backend   = gate.qual;
      end
      CIG_QM_LEVEL: begin
        gate.capture   = gate.qual;
        gate.nco_adv   = gate.qual;
      end
      CIG_QM_RISE: begin
        gate.capture   = gate.qual && !qual_prev_reg;
        gate.nco_adv   = gate.qual && !qual_prev_reg;
      end
      default: begin
        gate.capture   = !gate.qual && qual_prev_reg;
        gate.nco_adv   = !gate.qual && qual_prev_reg;
      end
    endcase
  end

endmodule // cig_qual_decode

/* File: rtl/cig_resampler.sv */
// second-order resampling comb: zero-stuff by L, integrate, pick every M
// assumes L <= M; one input sample gives at most one output
`timescale 1ns/1ps
module cig_resampler
  import cig_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        in_valid,
  input  wire cig_sample_t in_data,
  input  wire logic [8:0]  l_m1,
  input  wire logic [11:0] m_m1,
  output cig_rs_out_t      out_data,
  output logic             out_valid
);

  logic signed [47:0] int1_reg, int2_reg, dly1_reg, dly2_reg;
  logic        [12:0] phase_reg;
  logic signed [47:0] x_ext, int1_next, pick, comb1;
  logic        [13:0] l_ext, m_ext, sum;
  logic        [13:0] steps;
  logic               bypass, hit;

  // zero-stuffed sub-samples leave int1 fixed, so int2 grows by int1 each
  // step: the L sub-steps of one input fold into one multiply per clock
  always_comb begin
    x_ext     = 48'(in_data);
    l_ext     = 14'(l_m1) + 14'h0001;
    m_ext     = 14'(m_m1) + 14'h0001;
    bypass    = (l_m1 == 9'h000) && (m_m1 == 12'h000);
    int1_next = int1_reg + x_ext;
    sum       = 14'(phase_reg) + l_ext;
    hit       = sum >= m_ext;
    steps     = m_ext - 14'(phase_reg);
    pick      = int2_reg + 48'(int1_next * $signed({1'b0, steps}));
    comb1     = pick - dly1_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int1_reg  <= '0;
      int2_reg  <= '0;
      dly1_reg  <= '0;
      dly2_reg  <= '0;
      phase_reg <= '0;
    end else if (in_valid && !bypass) begin
      int1_reg <= int1_next;
      int2_reg <= int2_reg + 48'(int1_next * $signed({1'b0, l_ext}));
      if (hit) begin
        dly1_reg  <= pick;
        dly2_reg  <= comb1;
        phase_reg <= 13'(sum - m_ext);
      end else begin
        phase_reg <= 13'(sum);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else if (in_valid && bypass) begin
      out_data  <= 24'(in_data);
      out_valid <= 1'b1;
    end else if (in_valid && hit) begin
      out_data  <= 24'(comb1 - dly2_reg);
      out_valid <= 1'b1;
    end else begin
      out_valid <= 1'b0;
    end
  end

endmodule // cig_resampler

/* File: dv/cig_adc_model.sv */
// converter model for one wideband port: samples, exponent, qualifier
// assumes the bench requests levels; pins change just after clk edges
`timescale 1ns/1ps
module cig_adc_model
  import cig_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire cig_sample_t want_data,
  input  wire logic [2:0]  want_exp,
  input  wire logic        want_qual,
  output cig_sample_t      samples,
  output logic [2:0]       gain_exponent,
  output logic             qualifier
);
  logic [3:0] idle_cnt;

  // unqualified data is held only briefly, then toggles every cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samples       <= '0;
      gain_exponent <= '0;
      qualifier     <= 1'b0;
      idle_cnt      <= '0;
    end else begin
      qualifier     <= want_qual;
      gain_exponent <= want_exp;
      idle_cnt      <= want_qual ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
      samples       <= (!want_qual && idle_cnt > 4'h8) ? ~samples : want_data;
    end
  end
endmodule // cig_adc_model

/* File: dv/channel_input_gate_resampling_comb_test.sv */
// self-checking bench for one channel front end
// assumes converter models on ports A and B and a 250 MHz clock
`timescale 1ns/1ps
`include "cig_defs.svh"
module channel_input_gate_resampling_comb_test;
  import cig_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hreadyout, hresp, chan_sync, nco_advance, backend_run;
  logic        chan_valid, rs_valid, pa_q, pb_q, mon_on = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, rd0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, pa_e, pb_e;
  logic [3:0]  syn = 4'h0;
  logic [11:0] s;
  logic        want_q [2] = '{1'b0, 1'b0};
  logic [2:0]  want_e [2] = '{3'h0, 3'h0};
  cig_sample_t want_d [2] = '{16'h0, 16'h0};
  cig_sample_t pa_d, pb_d, chan_sample, last_s;
  cig_rs_out_t rs_data;
  cig_sample_t expq [$];
  int          n_mismatch = 0, check_count = 0, rs_cnt;
  logic [7:0]  ri [5] = '{`CIG_IDX_CONFIG, `CIG_IDX_DECIM, `CIG_IDX_INTERP,
                          `CIG_IDX_SCALE, 8'h00};
  logic [31:0] we [5] = '{32'h3FF, 32'hFFF, 32'h1FF, 32'hFFF, 32'h0};
  logic [31:0] rl [3] = '{32'h0, 32'h1, 32'h0};
  logic [31:0] rm [3] = '{32'h1, 32'h2, 32'h3};
  logic [31:0] re [3] = '{32'd30, 32'd40, 32'd15};
  logic [31:0] rsc [3] = '{32'h2, 32'h3, 32'h4};

  always #2 clk = ~clk;

  cig_adc_model i_adc_a (.clk(clk), .rstn(rstn), .want_data(want_d[0]),
    .want_exp(want_e[0]), .want_qual(want_q[0]), .samples(pa_d),
    .gain_exponent(pa_e), .qualifier(pa_q));
  cig_adc_model i_adc_b (.clk(clk), .rstn(rstn), .want_data(want_d[1]),
    .want_exp(want_e[1]), .want_qual(want_q[1]), .samples(pb_d),
    .gain_exponent(pb_e), .qualifier(pb_q));
  cig_channel_front i_cig_channel_front (.clk(clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_a_samples(pa_d),
    .port_a_gain_exponent(pa_e), .port_a_qualifier(pa_q),
    .port_b_samples(pb_d), .port_b_gain_exponent(pb_e),
    .port_b_qualifier(pb_q), .sync_pin_a(syn[0]), .sync_pin_b(syn[1]),
    .sync_pin_c(syn[2]), .sync_pin_d(syn[3]), .chan_sync(chan_sync),
    .nco_advance(nco_advance), .backend_run(backend_run),
    .chan_sample(chan_sample), .chan_valid(chan_valid),
    .rs_data(rs_data), .rs_valid(rs_valid));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // expected scaling: exponent inverted if sc[11], doubled if sc[10], plus scale, mod 8
  function automatic cig_sample_t scl(cig_sample_t d, logic [2:0] e,
                                      logic [11:0] sc);
    logic [3:0] ee;
    ee = sc[11] ? {1'b0, 3'h7 - e} : {1'b0, e};
    if (sc[10]) ee = ee << 1;
    return d >>> 3'(ee + sc[4:0]);
  endfunction

  task automatic capture(input logic [9:0] cfg, input logic [11:0] sc,
                         input logic q0, input int n);
    logic        b;
    cig_sample_t d;
    logic [2:0]  e;
    b = cfg[6];
    d = cig_sample_t'($urandom);
    e = 3'($urandom);
    mon_on <= 1'b0;
    want_q[b] <= q0;
    bus(1'b1, `CIG_IDX_SCALE, {20'h0, sc});
    bus(1'b1, `CIG_IDX_CONFIG, {22'h0, cfg});
    want_d[b] <= d;
    want_e[b] <= e;
    repeat (12) @(posedge clk);
    mon_on <= 1'b1;
    // weak select moves the weak field into the active slot
    repeat (n) expq.push_back(scl(d, e, cfg[9] ? {sc[11:5], sc[9:5]} : sc));
    want_q[b] <= ~q0;
    repeat (n) @(posedge clk);
    if (n > 1) want_q[b] <= q0;
    repeat (12) @(posedge clk);
    chk("pending captures", 32'h0, 32'(expq.size()));
    $display("capture test done, config %h", cfg);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one capture strobe per noted sample; bypass output follows it
  always @(posedge clk) begin
    if (mon_on && rs_valid === 1'b1)
      chk("rs_data", 32'(last_s), 32'(rs_data));
    if (mon_on && chan_valid === 1'b1 && expq.size() == 0)
      chk("extra capture", 32'h0, 32'h1);
    else if (mon_on && chan_valid === 1'b1)
      chk("chan_sample", 32'(expq.pop_front()), 32'(chan_sample));
    if (mon_on && chan_valid === 1'b1) last_s = chan_sample;
    if (mon_on)
      chk("nco_advance", {31'h0, chan_valid}, {31'h0, nco_advance});
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    rd = $urandom(92295);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (ri[i]) begin
      bus(1'b0, ri[i], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    foreach (ri[i]) begin
      bus(1'b1, ri[i], 32'hFFFF_FFFF);
      bus(1'b0, ri[i], 32'h0);
      chk("read back", we[i], rd);
    end
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("register test done");
    bus(1'b1, `CIG_IDX_DECIM, 32'h0);
    bus(1'b1, `CIG_IDX_INTERP, 32'h0);
    s = 12'($urandom) & 12'h01F;
    capture(10'h002, s, 1'b0, 1);
    capture(10'h043, s | 12'hC00, 1'b1, 1);
    capture(10'h201, (s << 5) | 12'h400, 1'b0, 5);
    chk("level backend", 32'h1, {31'h0, backend_run});
    mon_on <= 1'b0;
    bus(1'b1, `CIG_IDX_CONFIG, 32'h0);
    repeat (12) @(posedge clk);
    chk("blank sample", 32'h0, 32'(chan_sample));
    chk("blank valid", 32'h1, {31'h0, chan_valid});
    chk("blank nco", 32'h1, {31'h0, nco_advance});
    chk("blank backend", 32'h0, {31'h0, backend_run});
    want_q[0] <= 1'b1;
    repeat (12) @(posedge clk);
    chk("open sample", 32'(scl(want_d[0], want_e[0], (s << 5) | 12'h400)),
        32'(chan_sample));
    chk("open backend", 32'h1, {31'h0, backend_run});
    $display("blanking test done");
    for (int k = 0; k < 4; k++) begin
      syn <= 4'h1 << k;
      bus(1'b1, `CIG_IDX_CONFIG, 32'(k) << 7);
      repeat (8) @(posedge clk);
      chk("chan_sync", 32'h1, {31'h0, chan_sync});
    end
    $display("sync test done");
    foreach (rl[i]) begin
      bus(1'b1, `CIG_IDX_INTERP, rl[i]);
      bus(1'b1, `CIG_IDX_DECIM, rm[i]);
      bus(1'b1, `CIG_IDX_SCALE, rsc[i]);
      repeat (20) @(posedge clk);
      rs_cnt = 0;
      repeat (60) begin
        @(posedge clk);
        if (rs_valid === 1'b1) rs_cnt++;
      end
      chk("resampled count", re[i], 32'(rs_cnt));
    end
    bus(1'b0, `CIG_IDX_STATUS, 32'h0);
    rd0 = rd;
    bus(1'b0, `CIG_IDX_STATUS, 32'h0);
    chk("status", {16'(rd0[31:16] + 16'h0002), 16'h0003}, rd);
    $display("resampler test done");
    end_of_test();
  end
endmodule // channel_input_gate_resampling_comb_test
